//--- rtl/scs_store_seq.sv
`timescale 1ns/1ns
`include "scs_regs.svh"
// Overview of operation
// - Store dispatch forms low three microaddress bits from the store-mode field.
// - Mode 5 writes result register into accumulator chosen by instruction bits 09-12.
// - Basic mode asserts buffer wait; stalls only while a memory cycle is pending.
// - Condition dispatch enters instruction cycle only without interrupt, page fault or trap.
// - Mode 6 stores to accumulators when address bits 13-33 zero, else memory.
// - Accumulator-addressed stores raise fast reference flag; memory unit then aborts its cycle.
// - Memory mode fetches from PC+1 and latches it on memory response.
// - After memory-mode store: one no-op, buffer wait, state clear, then dispatch.
// - Mode 7 stores to effective address and accumulator, then wait, clear, dispatch.
// - Mode 3 stores to effective address, fetches, writes accumulator only if field nonzero.
// - Mode 3 skips the memory write-back when it would be redundant.
// - Mode 3 puts one no-op cycle between fetch and dispatch.
// - Compares and conditional jumps store nothing; fetch by test, then wait, clear, dispatch.
// - Skip ops write accumulator only if field nonzero; fetch PC+1 or PC+2.
// - Subtract/add-one-and-jump ops always write accumulator before wait, clear, dispatch.
// - Add/subtract-one-and-skip always write effective address; accumulator only conditionally.
// - Double store-both: high write pending, shift preset 35, high to accumulator, sign fill.
// - Shift result pair left by shift count, store low word in next accumulator.
// - Double accumulator-only results follow store-both flow; neither stores to the effective address.
// - Multi-accumulator results use own handler: store all, fetch, then dispatch.
// - Wait bit with memory cycle outstanding stops the clock until the pending cycle clears.
module scs_store_seq
   import scs_pkg::*;
#(
   parameter int DW = 36,
   parameter int AW = 4
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Execution-unit side
   input wire logic start_i,
   input wire logic [2:0] store_mode_i,
   input wire logic [8:0] opcode_i,
   input wire logic [AW-1:0] instr_accum_field_i,
   input wire logic [DW-1:0] result_register_i,
   input wire logic [DW-1:0] result_extension_register_i,
   input wire logic [DW-1:0] eff_addr_i,
   input wire logic [DW-1:0] pc_i,
   input wire logic test_satisfied_i,
   input wire logic redundant_write_i,
   input wire logic double_both_i,
   input wire logic double_ac_only_i,
   input wire logic multi_store_i,
   input wire logic intr_pending_i,
   input wire logic page_fault_pending_i,
   input wire logic trap_pending_i,
   output logic busy_o,
   output logic [2:0] store_microaddr_o,
   output logic state_clear_o,
   output logic next_instruction_condition_dispatch_o,
   output logic enter_instr_cycle_o,
   output logic [DW-1:0] next_pc_o,
   output logic memory_buffer_wait_o,
   output logic clock_stop_o,
   // Memory control unit side
   input wire logic mem_cycle_pending_i,
   input wire logic mem_response_i,
   output logic mem_req_o,
   output logic mem_write_o,
   output logic [DW-1:0] virtual_access_address_o,
   output logic [DW-1:0] mem_wdata_o,
   output logic fast_memory_reference_flag_o,
   output logic [DW-1:0] fetch_latched_addr_o,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   scs_acc_if #(.DW(DW), .AW(AW)) acc ();

   scs_state_t state_r, state_nxt;
   logic [2:0] mode_r;
   logic [8:0] op_r;
   logic [AW-1:0] ac_r;
   logic [DW-1:0] res_r, ext_r, ea_r, pc_r;
   logic test_r, redund_r, dbl_both_r, dbl_ac_r, multi_r;
   logic [5:0] shift_count_r;
   logic memwr_f, fetch_f, nop_f, acwr_f, wait_pend;
   logic [1:0] ctrl_r;
   logic [7:0] acc_sel_r;
   logic [31:0] count_r;
   logic aw_have_r, w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic do_write;
   logic [DW-1:0] fetch_addr;
   scs_next_fetch_t nf_sel;
   logic fetch_is_ac;
   logic done_evt;

   // ---------------------------------------------------------------
   // Instruction classification
   // ---------------------------------------------------------------
   wire [5:0] grp = op_r[8:3];
   wire is_nostore = grp == `SCS_OP_CAI || grp == `SCS_OP_CAM || grp == `SCS_OP_JUMP;
   wire is_skip = grp == `SCS_OP_SKIP;
   wire is_aossos = grp == `SCS_OP_AOS || grp == `SCS_OP_SOS;
   wire is_jump_wr = grp == `SCS_OP_AOJ || grp == `SCS_OP_SOJ || op_r == `SCS_OP_AOBJP || op_r == `SCS_OP_AOBJN;
   wire is_dbl = dbl_both_r | dbl_ac_r;
   wire ac_nz = (ac_r != '0);
   // Bits 13-33 zero address the accumulators
   wire ea_is_ac = (ea_r[DW-14:2] == '0);

   always_comb begin
      nf_sel = NF_PC1;
      if (test_r) begin
         if (is_jump_wr || grp == `SCS_OP_JUMP) begin
            nf_sel = NF_EA;
         end else if (is_nostore || is_skip || is_aossos) begin
            nf_sel = NF_PC2;
         end
      end
   end

   always_comb begin
      unique case (nf_sel)
         NF_PC2: fetch_addr = pc_r + DW'(2);
         NF_EA: fetch_addr = ea_r;
         default: fetch_addr = pc_r + DW'(1);
      endcase
   end

   assign fetch_is_ac = (fetch_addr[DW-14:2] == '0);

   // Step flags for the current store flow
   always_comb begin
      memwr_f = 1'b0;
      fetch_f = 1'b1;
      nop_f = 1'b0;
      acwr_f = 1'b0;
      if (multi_r) begin
         acwr_f = 1'b1;
      end else if (is_dbl) begin
         acwr_f = 1'b1;
      end else if (is_nostore) begin
         acwr_f = 1'b0;
      end else if (is_skip) begin
         acwr_f = ac_nz;
      end else if (is_aossos) begin
         memwr_f = 1'b1;
         acwr_f = ac_nz;
      end else if (is_jump_wr) begin
         acwr_f = 1'b1;
      end else begin
         unique case (mode_r)
            `SCS_SM_BASIC: begin
               acwr_f = 1'b1;
               fetch_f = 1'b0;
            end
            `SCS_SM_MEMORY: begin
               memwr_f = 1'b1;
               nop_f = 1'b1;
            end
            `SCS_SM_BOTH: begin
               memwr_f = 1'b1;
               acwr_f = 1'b1;
               fetch_f = 1'b0;
            end
            `SCS_SM_SELF: begin
               memwr_f = ~redund_r;
               acwr_f = ac_nz;
               nop_f = 1'b1;
            end
            default: begin
               fetch_f = 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Outstanding cycle holds FIN
   assign wait_pend = mem_cycle_pending_i;
   assign done_evt = (state_r == ST_FIN) && !wait_pend;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (start_i && ctrl_r[`SCS_CTRL_ENABLE_BIT]) begin
               state_nxt = ST_DISP;
            end
         end
         ST_DISP: begin
            if (memwr_f) begin
               state_nxt = ST_MEMWR;
            end else if (multi_r) begin
               state_nxt = ST_LOW;
            end else if (fetch_f) begin
               state_nxt = ST_FETCH;
            end else begin
               state_nxt = ST_FIN;
            end
         end
         ST_MEMWR: begin
            if (fast_memory_reference_flag_o || mem_response_i) begin
               state_nxt = fetch_f ? ST_FETCH : ST_FIN;
            end
         end
         ST_FETCH: begin
            if (fast_memory_reference_flag_o || mem_response_i) begin
               if (nop_f) begin
                  state_nxt = ST_NOP;
               end else if (is_dbl && !multi_r) begin
                  state_nxt = ST_SHIFT;
               end else begin
                  state_nxt = ST_FIN;
               end
            end
         end
         ST_NOP: state_nxt = ST_FIN;
         ST_SHIFT: state_nxt = ST_LOW;
         ST_LOW: state_nxt = multi_r ? ST_FETCH : ST_FIN;
         ST_FIN: begin
            if (!wait_pend) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (ctrl_r[`SCS_CTRL_ABORT_BIT]) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Operand capture, double alignment
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r <= 3'h0;
         op_r <= 9'h000;
         ac_r <= '0;
         res_r <= '0;
         ext_r <= '0;
         ea_r <= '0;
         pc_r <= '0;
         test_r <= 1'b0;
         redund_r <= 1'b0;
         dbl_both_r <= 1'b0;
         dbl_ac_r <= 1'b0;
         multi_r <= 1'b0;
         shift_count_r <= 6'h00;
      end else if (state_r == ST_IDLE && state_nxt == ST_DISP) begin
         mode_r <= store_mode_i;
         op_r <= opcode_i;
         ac_r <= instr_accum_field_i;
         res_r <= result_register_i;
         ext_r <= result_extension_register_i;
         ea_r <= eff_addr_i;
         pc_r <= pc_i;
         test_r <= test_satisfied_i;
         redund_r <= redundant_write_i;
         dbl_both_r <= double_both_i;
         dbl_ac_r <= double_ac_only_i;
         multi_r <= multi_store_i;
         shift_count_r <= `SCS_SC_PRESET;
      end else if (state_r == ST_DISP && is_dbl && !multi_r) begin
         res_r <= {DW{res_r[DW-1]}};
      end else if (state_r == ST_SHIFT) begin
         res_r <= DW'({res_r, ext_r} >> (DW - int'(shift_count_r)));
      end
   end

   // Microaddress low bits from mode
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         store_microaddr_o <= 3'h0;
      end else if (state_r == ST_IDLE && state_nxt == ST_DISP) begin
         store_microaddr_o <= store_mode_i;
      end
   end

   // High/only word in DISP, next accumulator in LOW
   always_comb begin
      acc.we = 1'b0;
      acc.waddr = ac_r;
      acc.wdata = res_r;
      if (state_r == ST_DISP && acwr_f) begin
         acc.we = 1'b1;
      end else if (state_r == ST_MEMWR && fast_memory_reference_flag_o) begin
         acc.we = 1'b1;
         acc.waddr = ea_r[AW-1:0];
      end else if (state_r == ST_LOW) begin
         acc.we = 1'b1;
         acc.waddr = ac_r + AW'(1);
         acc.wdata = multi_r ? ext_r : res_r;
      end
   end
   assign acc.raddr = acc_sel_r[AW-1:0];

   scs_acc_file #(.DW(DW), .AW(AW)) u_acc (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .acc(acc)
   );

   // ---------------------------------------------------------------
   // Memory control unit requests
   // ---------------------------------------------------------------
   // Drops at the response edge: no double issue
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_req_o <= 1'b0;
         mem_write_o <= 1'b0;
         virtual_access_address_o <= '0;
         mem_wdata_o <= '0;
         fast_memory_reference_flag_o <= 1'b0;
      end else begin
         mem_req_o <= (state_nxt == ST_MEMWR) || (state_nxt == ST_FETCH);
         mem_write_o <= (state_nxt == ST_MEMWR);
         mem_wdata_o <= res_r;
         if (state_nxt == ST_MEMWR) begin
            virtual_access_address_o <= ea_r;
            fast_memory_reference_flag_o <= ea_is_ac;
         end else if (state_nxt == ST_FETCH) begin
            virtual_access_address_o <= fetch_addr;
            fast_memory_reference_flag_o <= fetch_is_ac;
         end else begin
            fast_memory_reference_flag_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fetch_latched_addr_o <= '0;
      end else if (state_r == ST_FETCH && (mem_response_i || fast_memory_reference_flag_o)) begin
         fetch_latched_addr_o <= virtual_access_address_o;
      end
   end

   // Stop until a real request is answered
   assign clock_stop_o = ((state_r == ST_MEMWR || state_r == ST_FETCH) && !fast_memory_reference_flag_o &&
                          !mem_response_i) || ((state_r == ST_FIN) && wait_pend);
   assign memory_buffer_wait_o = (state_r == ST_FIN);
   assign busy_o = (state_r != ST_IDLE);

   // ---------------------------------------------------------------
   // Condition dispatch
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_clear_o <= 1'b0;
         next_instruction_condition_dispatch_o <= 1'b0;
         enter_instr_cycle_o <= 1'b0;
         next_pc_o <= '0;
      end else begin
         state_clear_o <= done_evt && (state_r != ST_IDLE);
         next_instruction_condition_dispatch_o <= done_evt;
         enter_instr_cycle_o <= done_evt && !intr_pending_i && !page_fault_pending_i &&
                                !trap_pending_i;
         if (done_evt) begin
            next_pc_o <= fetch_addr;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite register slave
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready = !w_have_r;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_r <= 1'b0;
         end
      end
   end

   wire wr_known = (aw_addr_r <= `SCS_ACC_DATA_OFS) && (aw_addr_r[1:0] == 2'h0);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Abort is a one-shot
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `SCS_CTRL_RESET;
         acc_sel_r <= 8'h00;
      end else begin
         ctrl_r[`SCS_CTRL_ABORT_BIT] <= 1'b0;
         if (do_write && w_strb_r[0] && aw_addr_r == `SCS_CTRL_OFS) begin
            ctrl_r <= w_data_r[1:0];
         end
         if (do_write && w_strb_r[0] && aw_addr_r == `SCS_ACC_SEL_OFS) begin
            acc_sel_r <= w_data_r[7:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_r <= 32'h0;
      end else if (done_evt) begin
         count_r <= count_r + 32'h1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         unique case (s_axi_araddr)
            `SCS_CTRL_OFS: s_axi_rdata <= {30'h0, ctrl_r};
            `SCS_STATUS_OFS: s_axi_rdata <= {18'h0, store_microaddr_o, mem_cycle_pending_i, clock_stop_o,
                                             busy_o, state_r};
            `SCS_COUNT_OFS: s_axi_rdata <= count_r;
            `SCS_ACC_SEL_OFS: s_axi_rdata <= {24'h0, acc_sel_r};
            `SCS_ACC_DATA_OFS: s_axi_rdata <= acc.rdata[31:0];
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

//--- common/scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// Register byte offsets
`define SCS_CTRL_OFS 8'h00
`define SCS_STATUS_OFS 8'h04
`define SCS_COUNT_OFS 8'h08
`define SCS_ACC_SEL_OFS 8'h0c
`define SCS_ACC_DATA_OFS 8'h10

// Control fields and reset value
`define SCS_CTRL_ENABLE_BIT 0
`define SCS_CTRL_ABORT_BIT 1
`define SCS_CTRL_RESET 2'h1

// Store-mode dispatch codes
`define SCS_SM_SELF 3'h3
`define SCS_SM_BASIC 3'h5
`define SCS_SM_MEMORY 3'h6
`define SCS_SM_BOTH 3'h7

// Opcode groups by the upper six opcode bits; AOBJP and AOBJN are full nine-bit opcodes
`define SCS_OP_CAI 6'h18
`define SCS_OP_CAM 6'h19
`define SCS_OP_JUMP 6'h1a
`define SCS_OP_SKIP 6'h1b
`define SCS_OP_AOJ 6'h1c
`define SCS_OP_AOS 6'h1d
`define SCS_OP_SOJ 6'h1e
`define SCS_OP_SOS 6'h1f
`define SCS_OP_AOBJP 9'haa
`define SCS_OP_AOBJN 9'hab

// Shift preset for aligning a double result
`define SCS_SC_PRESET 6'h23

`endif

//--- common/scs_pkg.sv
package scs_pkg;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_DISP  = 8'h02,
      ST_MEMWR = 8'h04,
      ST_FETCH = 8'h08,
      ST_NOP   = 8'h10,
      ST_SHIFT = 8'h20,
      ST_LOW   = 8'h40,
      ST_FIN   = 8'h80
   } scs_state_t;

   typedef enum logic [1:0] {
      NF_PC1 = 2'h0,
      NF_PC2 = 2'h1,
      NF_EA  = 2'h2
   } scs_next_fetch_t;

endpackage

//--- common/scs_acc_if.sv
`timescale 1ns/1ns
interface scs_acc_if #(parameter int DW = 36, parameter int AW = 4);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;

   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- rtl/scs_acc_file.sv
`timescale 1ns/1ns
module scs_acc_file #(
   parameter int DW = 36,
   parameter int AW = 4
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   scs_acc_if.mem acc
);

   logic [DW-1:0] words [0:(1<<AW)-1];
   logic [DW-1:0] rdata_r;

   // Storage has no reset; only the read register does
   always_ff @(posedge clock_i) begin
      if (acc.we) begin
         words[acc.waddr] <= acc.wdata;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= words[acc.raddr];
      end
   end

   assign acc.rdata = rdata_r;

endmodule

//--- sim/scs_sva.sv
`timescale 1ns/1ns
module scs_sva #(parameter int DW = 36) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [2:0] store_mode_i,
   input wire logic intr_pending_i,
   input wire logic page_fault_pending_i,
   input wire logic trap_pending_i,
   input wire logic mem_cycle_pending_i,
   input wire logic mem_response_i,
   input wire logic busy_o,
   input wire logic [2:0] store_microaddr_o,
   input wire logic state_clear_o,
   input wire logic next_instruction_condition_dispatch_o,
   input wire logic enter_instr_cycle_o,
   input wire logic memory_buffer_wait_o,
   input wire logic clock_stop_o,
   input wire logic mem_req_o,
   input wire logic mem_write_o,
   input wire logic [DW-1:0] virtual_access_address_o,
   input wire logic fast_memory_reference_flag_o,
   input wire logic [DW-1:0] fetch_latched_addr_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wire logic dsp = next_instruction_condition_dispatch_o;
   wire logic fast = fast_memory_reference_flag_o;
   wire logic [DW-1:0] virtual_access_address = virtual_access_address_o;
   microaddr_mode_a: assert property ($rose(busy_o) |-> store_microaddr_o == $past(store_mode_i))
      else $error("microaddress wrong");
   enter_gate_a: assert property (dsp |-> enter_instr_cycle_o == !$past(intr_pending_i || page_fault_pending_i || trap_pending_i))
      else $error("entry wrong");
   clear_with_dispatch_a: assert property (dsp |-> state_clear_o && !busy_o)
      else $error("no state clear");
   wait_then_dispatch_a: assert property (dsp |-> $past(memory_buffer_wait_o))
      else $error("no buffer wait");
   pending_stall_a: assert property (memory_buffer_wait_o && mem_cycle_pending_i |-> clock_stop_o ##1 !dsp)
      else $error("no stall");
   fast_flag_addr_a: assert property (fast |-> mem_req_o && virtual_access_address[22:2] == '0)
      else $error("fast flag address");
   request_hold_a: assert property (mem_req_o && !mem_response_i && !fast |=> mem_req_o && $stable(virtual_access_address) && $stable(mem_write_o))
      else $error("request changed");
   fetch_latch_a: assert property (mem_req_o && !mem_write_o && mem_response_i |=> fetch_latched_addr_o == $past(virtual_access_address))
      else $error("no latch");
   dispatch_pulse_a: assert property (dsp |=> !dsp)
      else $error("dispatch too long");
endmodule

//--- sim/scs_mem_model.sv
`timescale 1ns/1ns
module scs_mem_model (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire logic write_i,
   input wire logic fast_i,
   input wire logic hold_i,
   output logic resp_o,
   output logic pend_o,
   output logic [7:0] wr_count_o
);
   logic [2:0] wait_r;
   // Writes answer fast, fetches slow
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 3'h0;
         resp_o <= 1'b0;
         wr_count_o <= 8'h00;
      end else begin
         resp_o <= 1'b0;
         if (!req_i || fast_i || resp_o) begin
            wait_r <= 3'h0;
         end else if (wait_r == (write_i ? 3'h1 : 3'h4)) begin
            resp_o <= 1'b1;
            wr_count_o <= wr_count_o + 8'(write_i);
         end else begin
            wait_r <= wait_r + 3'h1;
         end
      end
   end
   assign pend_o = hold_i || (req_i && !fast_i);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   typedef struct {logic [2:0] m; logic [8:0] o; logic [3:0] a; bit f, r, t; int p, w; bit c;} scs_row_t;
   logic clock_i = 0, rst_n_i = 0, start_i = 0, test_satisfied_i = 0, redundant_write_i = 0, hold = 0;
   logic double_both_i = 0, double_ac_only_i = 0, multi_store_i = 0, intr_pending_i = 0;
   logic [2:0] store_mode_i = 0, store_microaddr_o;
   logic [8:0] opcode_i = 0;
   logic [3:0] instr_accum_field_i = 0;
   logic [35:0] result_register_i = 0, result_extension_register_i = 36'h987654321, eff_addr_i = 0, x;
   logic [35:0] next_pc_o, virtual_access_address_o, mem_wdata_o, fetch_latched_addr_o;
   logic busy_o, state_clear_o, next_instruction_condition_dispatch_o, enter_instr_cycle_o, mem_req_o;
   logic memory_buffer_wait_o, clock_stop_o, mem_cycle_pending_i, mem_response_i, mem_write_o;
   logic fast_memory_reference_flag_o;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, wcnt, w0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, e;
   int n_fail = 0, n_compared = 0, k;
   scs_row_t rows[12] = '{
      '{3'h5, 9'h0, 4'h3, 0, 0, 0, 0, 0, 1}, '{3'h6, 9'h0, 4'h1, 0, 0, 0, 0, 1, 0},
      '{3'h6, 9'h0, 4'h2, 1, 0, 0, 0, 0, 1}, '{3'h7, 9'h0, 4'h4, 0, 0, 0, 0, 1, 1},
      '{3'h3, 9'h0, 4'h0, 0, 0, 0, 0, 1, 0}, '{3'h3, 9'h0, 4'h5, 0, 1, 0, 0, 0, 1},
      '{3'h5, 9'h0c0, 4'h7, 0, 0, 1, 1, 0, 0}, '{3'h5, 9'h0d0, 4'h7, 0, 0, 1, 2, 0, 0},
      '{3'h5, 9'h0d8, 4'h6, 0, 0, 1, 1, 0, 1}, '{3'h5, 9'h0e0, 4'h9, 0, 0, 1, 2, 0, 1},
      '{3'h5, 9'h0f8, 4'h0, 0, 0, 0, 0, 1, 0}, '{3'h5, 9'h0aa, 4'ha, 0, 0, 1, 2, 0, 1}};
   scs_store_seq u_scs_store_seq (.*, .pc_i(36'h40), .page_fault_pending_i(intr_pending_i),
      .trap_pending_i(intr_pending_i), .s_axi_wstrb(4'hf));
   scs_mem_model u_scs_mem_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(mem_req_o),
      .write_i(mem_write_o), .fast_i(fast_memory_reference_flag_o), .hold_i(hold),
      .resp_o(mem_response_i), .pend_o(mem_cycle_pending_i), .wr_count_o(wcnt));
   always #2 clock_i = ~clock_i;
   task automatic ck(input bit ok, input string m);
      n_compared++;
      if (!ok) begin
         n_fail++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge clock_i);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do begin
         @(posedge clock_i);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      e = s_axi_rresp;
   endtask
   task automatic acc(input logic [3:0] a);
      wr(8'h0c, {28'h0, a});
      rd(8'h10);
   endtask
   task automatic go();
      start_i <= 1;
      @(posedge clock_i);
      start_i <= 0;
   endtask
   task automatic run(input logic [2:0] m, input logic [8:0] o, input logic [3:0] a, input logic [35:0] ea,
                      input bit t, input bit r);
      store_mode_i <= m;
      opcode_i <= o;
      instr_accum_field_i <= a;
      eff_addr_i <= ea;
      test_satisfied_i <= t;
      redundant_write_i <= r;
      result_register_i <= result_register_i + 36'h111;
      go();
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (!next_instruction_condition_dispatch_o);
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1;
      rd(8'h00);
      ck(d === 32'h1, "control reset value");
      rd(8'h40);
      ck(e === 2'h2 && d === 32'h0, "unmapped read");
      foreach (rows[i]) begin
         w0 = wcnt;
         run(rows[i].m, rows[i].o, rows[i].a, rows[i].f ? 36'h2 : 36'h100, rows[i].t, rows[i].r);
         x = rows[i].p == 2 ? eff_addr_i : 36'h41 + rows[i].p;
         ck(next_pc_o === x && enter_instr_cycle_o === 1'b1, "next fetch");
         ck(wcnt - w0 === 8'(rows[i].w), "memory writes");
         acc(rows[i].a);
         ck((d === result_register_i[31:0]) === rows[i].c, "accumulator");
      end
      double_ac_only_i <= 1;
      w0 = wcnt;
      run(3'h7, 9'h0, 4'h8, 36'h100, 0, 0);
      double_ac_only_i <= 0;
      acc(4'h9);
      ck(d === result_extension_register_i[32:1] && wcnt === w0, "double low word");
      double_both_i <= 1;
      run(3'h7, 9'h0, 4'hb, 36'h100, 0, 0);
      double_both_i <= 0;
      acc(4'hb);
      ck(d === result_register_i[31:0], "double high word");
      multi_store_i <= 1;
      run(3'h7, 9'h0, 4'he, 36'h100, 0, 0);
      multi_store_i <= 0;
      acc(4'hf);
      ck(d === result_extension_register_i[31:0], "multi store");
      intr_pending_i <= 1;
      run(3'h5, 9'h0, 4'h1, 36'h100, 0, 0);
      intr_pending_i <= 0;
      ck(enter_instr_cycle_o === 1'b0, "entry while pending");
      hold <= 1;
      fork
         begin
            repeat (20) @(posedge clock_i);
            hold <= 0;
         end
      join_none
      run(3'h5, 9'h0, 4'h1, 36'h100, 0, 0);
      ck(k > 20, "no stall");
      go();
      rst_n_i <= 0;
      @(posedge clock_i);
      rst_n_i <= 1;
      @(posedge clock_i);
      ck(busy_o === 1'b0 && next_pc_o === 36'h0, "state after reset");
      wr(8'h00, 32'h0);
      go();
      @(posedge clock_i);
      ck(busy_o === 1'b0, "start while disabled");
      end_of_test();
   end
endmodule
bind scs_store_seq scs_sva #(.DW(DW)) u_scs_sva (.*);
